// ===== dv/bil_flash_model.sv
`default_nettype none
module bil_flash_model (
  // Flash pins
  input  wire logic        ss_n_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  output var  logic        miso_o,
  output var  logic [3:0]  dq_o,
  // Bench side
  input  wire logic        quad_i,
  input  wire logic [7:0]  img_i [16],
  output var  logic [31:0] cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int edges = 0;
  int k;

  initial begin
    miso_o = 1'b0;
    dq_o = 4'h0;
    cmd_o = 32'h0;
  end

  always @(posedge sclk_i or posedge ss_n_i) begin
    if (ss_n_i) edges <= 0;
    else begin
      edges <= edges + 1;
      if (edges < 32) cmd_o <= {cmd_o[30:0], mosi_i};
    end
  end

  // Lines toggle while deselected and during the command so a stale bit is never read as valid
  always @(negedge sclk_i or posedge ss_n_i) begin
    k = edges - 32;
    if (ss_n_i || k < 0) begin
      miso_o <= ~miso_o;
      dq_o <= ~dq_o;
    end else if (quad_i)
      dq_o <= k[0] ? img_i[k/2][7:4] : img_i[k/2][3:0];
    else
      miso_o <= img_i[k/8][k%8];
  end
endmodule
`default_nettype wire

// ===== dv/bil_loader_assertions.sv
`default_nettype none
module bil_loader_assertions #(
  parameter int ADDR_W = 17,
  parameter int OTP_W  = 11
) (
  // Clocks and reset
  input wire logic              clock_i,
  input wire logic              nrst_i,
  input wire logic              link_clk_i,
  // Straps and pins
  input wire logic [31:0]       sec_word_i,
  input wire logic              pulldown_en_o,
  input wire logic [7:0]        pin_en_o,
  input wire logic              ss_n_o,
  input wire logic              sclk_o,
  // Memories
  input wire logic              otp_rd_o,
  input wire logic [OTP_W-1:0]  otp_addr_o,
  input wire logic              ram_we_o,
  input wire logic [ADDR_W-1:0] ram_addr_o,
  // Link and status
  input wire logic              link_en_o,
  input wire logic              link_tx_valid_o,
  input wire logic              link_tx_ctrl_o,
  input wire logic [7:0]        link_tx_data_o,
  input wire logic              run_o,
  input wire logic [ADDR_W-1:0] run_addr_o,
  input wire logic              fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int                cyc;
  int                hi;
  logic [ADDR_W-1:0] wr;
  logic              seen;

  // Saturates so a long boot cannot wrap it
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc <= 0;
      hi <= 0;
      wr <= '0;
      seen <= 1'b0;
    end else begin
      if (cyc < 4000) cyc <= cyc + 1;
      hi <= sclk_o ? hi + 1 : 0;
      if (ram_we_o) wr <= wr + 1'b1;
      if (otp_rd_o) seen <= 1'b1;
    end
  end

  AST_BOOT_WAIT: assert property (@(posedge clock_i)
    disable iff (!nrst_i) cyc < 1500 |-> ss_n_o && !otp_rd_o && !link_en_o)
    else $error("Boot activity before reset delay");
  AST_PULLDOWN: assert property (@(posedge clock_i)
    disable iff (!nrst_i) !run_o |-> pulldown_en_o)
    else $error("Pull-downs off before run");
  AST_SCLK_IDLE: assert property (@(posedge clock_i)
    disable iff (!nrst_i) ss_n_o |-> !sclk_o)
    else $error("Serial clock not idle low");
  AST_SCLK_HALF: assert property (@(posedge clock_i)
    disable iff (!nrst_i) $fell(sclk_o) && !ss_n_o
    |-> hi == (pin_en_o == 8'hF3 ? 4 : 80))
    else $error("Serial clock high time wrong");
  AST_SEC_OTP: assert property (@(posedge clock_i)
    disable iff (!nrst_i) otp_rd_o |-> sec_word_i[5] && ss_n_o)
    else $error("OTP read without secure boot");
  AST_OTP_FIRST: assert property (@(posedge clock_i)
    disable iff (!nrst_i) otp_rd_o && !seen |-> otp_addr_o == '0)
    else $error("First OTP read not at zero");
  AST_RAM_SEQ: assert property (@(posedge clock_i)
    disable iff (!nrst_i) ram_we_o |-> ram_addr_o == wr)
    else $error("RAM write address out of order");
  AST_RUN_OK: assert property (@(posedge clock_i)
    disable iff (!nrst_i) run_o |-> !fail_o && run_addr_o == '0)
    else $error("Run with failure or nonzero address");
  AST_LINK_END: assert property (@(posedge link_clk_i)
    disable iff (!nrst_i) link_tx_valid_o |-> link_tx_ctrl_o
    && link_tx_data_o == 8'h01)
    else $error("Link reply is not an end token");
endmodule

bind bil_loader bil_loader_assertions #(.ADDR_W(ADDR_W), .OTP_W(OTP_W))
  i_bil_loader_assertions (.clock_i, .nrst_i, .link_clk_i, .sec_word_i,
  .pulldown_en_o, .pin_en_o, .ss_n_o, .sclk_o, .otp_rd_o, .otp_addr_o,
  .ram_we_o, .ram_addr_o, .link_en_o, .link_tx_valid_o, .link_tx_ctrl_o,
  .link_tx_data_o, .run_o, .run_addr_o, .fail_o);
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 0, link_clk_i = 0, nrst_i = 0, quad = 0;
  logic [1:0]  boot_mode_i = 0;
  logic [31:0] sec_word_i = 0, otp_data_i = 0, seed = 32'h7641, cmd, ack;
  logic        miso_i, otp_vld_i = 0, link_rx_valid_i = 0, link_rx_ctrl_i = 0;
  logic        slv_ss_n_i = 1, slv_sclk_i = 0, slv_mosi_i = 0;
  logic [3:0]  dq_i;
  logic [7:0]  link_rx_data_i = 0, pin_en_o, link_tx_data_o, ram_data_o;
  logic        pulldown_en_o, ss_n_o, sclk_o, mosi_o, mosi_oe_n_o, otp_rd_o;
  logic        ram_we_o, link_en_o, link_rx_ready_o, link_tx_valid_o;
  logic        link_tx_ctrl_o, chan_alloc_o, run_o, fail_o;
  logic [10:0] otp_addr_o;
  logic [16:0] ram_addr_o, run_addr_o;
  logic [31:0] link_tx_chan_o;
  logic [7:0]  img [16];
  logic [24:0] expq [$];
  int          fails = 0, checks_done = 0, cyc = 0, txn = 0;

  bil_loader i_bil_loader (.clock_i, .nrst_i, .link_clk_i, .boot_mode_i,
    .sec_word_i, .pulldown_en_o, .pin_en_o, .ss_n_o, .sclk_o, .mosi_o,
    .mosi_oe_n_o, .miso_i, .dq_i, .slv_ss_n_i, .slv_sclk_i, .slv_mosi_i,
    .otp_rd_o, .otp_addr_o, .otp_data_i, .otp_vld_i, .ram_we_o, .ram_addr_o,
    .ram_data_o, .link_en_o, .link_rx_valid_i, .link_rx_ctrl_i,
    .link_rx_data_i, .link_rx_ready_o, .link_tx_valid_o, .link_tx_ctrl_o,
    .link_tx_data_o, .link_tx_chan_o, .chan_alloc_o, .run_o, .run_addr_o,
    .fail_o);
  bil_flash_model i_bil_flash_model (.ss_n_i(ss_n_o), .sclk_i(sclk_o),
    .mosi_i(mosi_o), .miso_o(miso_i), .dq_o(dq_i), .quad_i(quad),
    .img_i(img), .cmd_o(cmd));

  initial forever #5 clock_i = ~clock_i;
  initial begin
    #7;
    forever #32 link_clk_i = ~link_clk_i;
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Kind 0 good checksum, 1 skip value, 2 corrupted checksum
  task automatic build(int s, int kind);
    logic [31:0] c;
    c = bil_pkg::BIL_CRC_INIT;
    for (int i = 0; i < 4 * s + 4; i++) begin
      if (i < 4) img[i] = 8'(s >> (8 * i));
      else begin
        seed = lfsr(seed);
        img[i] = seed[7:0];
        expq.push_back({17'(i - 4), img[i]});
      end
      c = c ^ 32'(img[i]);
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ bil_pkg::BIL_CRC_POLY : c >> 1;
    end
    c = ~c;
    if (kind == 1) c = bil_pkg::BIL_CRC_SKIP;
    if (kind == 2) c = ~c;
    for (int i = 0; i < 4; i++)
      img[4 * s + 4 + i] = c[8 * i +: 8];
  endtask

  task automatic boot(logic [1:0] mode, logic sec, int s, int kind);
    @(negedge clock_i);
    nrst_i = 0;
    boot_mode_i = mode;
    seed = lfsr(seed);
    sec_word_i = {seed[31:6], sec, seed[4:0]};
    quad = (mode == 2'h0);
    build(s, kind);
    repeat (4) @(negedge clock_i);
    check(pulldown_en_o, 1);
    nrst_i = 1;
  endtask

  task automatic await_ss(logic [7:0] pins);
    int n;
    n = 0;
    while (ss_n_o !== 1'b0 && n++ < 3000) @(negedge clock_i);
    check(pin_en_o, pins);
  endtask

  task automatic finish(logic ok);
    int n;
    n = 0;
    while (run_o !== 1'b1 && fail_o !== 1'b1 && n++ < 40000)
      @(negedge clock_i);
    check({run_o, fail_o}, {ok, !ok});
    check(run_addr_o, 0);
    check(expq.size(), 0);
  endtask

  task automatic send(logic ctrl, logic [7:0] d);
    int n;
    n = 0;
    @(negedge link_clk_i);
    link_rx_valid_i = 1;
    link_rx_ctrl_i = ctrl;
    link_rx_data_i = d;
    do @(posedge link_clk_i); while (link_rx_ready_o !== 1'b1 && n++ < 200);
    @(negedge link_clk_i);
    link_rx_valid_i = 0;
    link_rx_data_i = ~d;
  endtask

  task automatic slave(logic cpol);
    slv_sclk_i = cpol;
    repeat (1600) @(negedge clock_i);
    slv_ss_n_i = 0;
    check(pin_en_o, 8'h07);
    for (int i = 0; i < 96; i++) begin
      repeat (6) @(negedge clock_i);
      slv_sclk_i = 0;
      slv_mosi_i = img[i / 8][i % 8];
      repeat (6) @(negedge clock_i);
      slv_sclk_i = 1;
    end
    repeat (6) @(negedge clock_i);
    slv_ss_n_i = 1;
    slv_sclk_i = cpol;
  endtask

  always @(posedge clock_i)
    if (ram_we_o === 1'b1) begin
      if (expq.size() == 0) check(ram_we_o, 0);
      else check({ram_addr_o, ram_data_o}, expq.pop_front());
    end

  always @(posedge clock_i) begin
    otp_vld_i <= otp_rd_o;
    otp_data_i <= ~otp_data_i;
    if (otp_rd_o)
      for (int i = 0; i < 4; i++)
        otp_data_i[8*i +: 8] <= img[4 * int'(otp_addr_o) + i];
  end

  always @(posedge link_clk_i)
    if (link_tx_valid_o === 1'b1) begin
      txn++;
      check(link_tx_chan_o, ack);
      check({link_tx_ctrl_o, link_tx_data_o}, 9'h101);
    end

  always @(posedge clock_i)
    if (++cyc == 60000) begin
      fails++;
      wrap_up();
    end

  initial begin
    int n;
    for (int m = 0; m < 2; m++) begin
      boot(2'(m), 0, 2 - m, m);
      await_ss(m ? 8'h0F : 8'hF3);
      finish(1);
      check(cmd, {bil_pkg::BIL_CMD_READ, bil_pkg::BIL_START_ADDR});
    end
    boot(2'h0, 1, 2, 2);
    finish(0);
    check(ss_n_o, 1);
    for (int m = 0; m < 2; m++) begin
      boot(2'h2, 0, 1, m);
      slave(m[0]);
      finish(1);
    end
    for (int m = 0; m < 2; m++) begin
      boot(2'h3, 0, 1, 0);
      link_rx_data_i = 0;
      ack = m ? bil_pkg::BIL_NULL_CHAN : lfsr(seed);
      n = 0;
      while (link_en_o !== 1'b1 && n++ < 3000) @(negedge clock_i);
      check(chan_alloc_o, 1);
      check(pin_en_o, 0);
      for (int i = 0; i < 4; i++) send(0, ack[8*i +: 8]);
      for (int i = 0; i < 12; i++) send(0, img[i]);
      send(1, bil_pkg::BIL_TOK_END);
      finish(1);
      repeat (8) @(negedge link_clk_i);
      check(txn, 1);
      check(chan_alloc_o, 0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== src/bil_loader.sv
// Summary of operation
// RULE1: Hold reset, then boot after 15 us.
// RULE2: GPIO pull-downs enabled during reset.
// RULE3: Security bit 5 forces OTP boot.
// RULE4: Image is size, words, CRC; skip value.
// RULE5: Size and CRC arrive low byte first.
// RULE6: Load from RAM base, start there.
// RULE7: Checksum covers size and program bytes.
// RULE8: Reflected CRC-32, preset ones, inverted result.
// RULE9: Quad mode: six pins, 50 MHz ratio clock.
// RULE10: Master sends READ, address zero, mode 0.
// RULE11: Quad bytes arrive low nibble first.
// RULE12: Single master: four pins, 2.5 MHz ratio.
// RULE13: Single-bit bytes arrive LSB first.
// RULE14: Slave: three pins, modes 0/0 and 1/1.
// RULE15: Link boot: enable link 2 us, TX low.
// RULE16: Sender holds our RX wires low first.
// RULE17: Link: alloc, ack word, image, END, END.
// RULE18: Null ack channel means no END reply.
// RULE19: Secure boot reads OTP from address 0.
// RULE20: Bad checksum never jumps to program.
`default_nettype none

module bil_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] s0;
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  wire  [W-1:0] next_q = (s1 & s2) | (q_o & (s1 ^ s2));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s0  <= '0;
      s1  <= '0;
      s2  <= '0;
      q_o <= '0;
    end else begin
      s0  <= d_i;
      s1  <= s0;
      s2  <= s1;
      q_o <= next_q;
    end
  end
endmodule

module bil_loader #(
  parameter int ADDR_W = 17,
  parameter int OTP_W  = 11
) (
  // Clocks and reset
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic              link_clk_i,
  // Straps and security word
  input  wire logic [1:0]        boot_mode_i,
  input  wire logic [31:0]       sec_word_i,
  // Pin control
  output var  logic              pulldown_en_o,
  output var  logic [7:0]        pin_en_o,
  // Flash master
  output var  logic              ss_n_o,
  output var  logic              sclk_o,
  output var  logic              mosi_o,
  output var  logic              mosi_oe_n_o,
  input  wire logic              miso_i,
  input  wire logic [3:0]        dq_i,
  // External master
  input  wire logic              slv_ss_n_i,
  input  wire logic              slv_sclk_i,
  input  wire logic              slv_mosi_i,
  // OTP
  output var  logic              otp_rd_o,
  output var  logic [OTP_W-1:0]  otp_addr_o,
  input  wire logic [31:0]       otp_data_i,
  input  wire logic              otp_vld_i,
  // RAM
  output var  logic              ram_we_o,
  output var  logic [ADDR_W-1:0] ram_addr_o,
  output var  logic [7:0]        ram_data_o,
  // Link
  output var  logic              link_en_o,
  input  wire logic              link_rx_valid_i,
  input  wire logic              link_rx_ctrl_i,
  input  wire logic [7:0]        link_rx_data_i,
  output var  logic              link_rx_ready_o,
  output var  logic              link_tx_valid_o,
  output var  logic              link_tx_ctrl_o,
  output var  logic [7:0]        link_tx_data_o,
  output var  logic [31:0]       link_tx_chan_o,
  // Status
  output var  logic              chan_alloc_o,
  output var  logic              run_o,
  output var  logic [ADDR_W-1:0] run_addr_o,
  output var  logic              fail_o
);
  localparam int TW = $clog2(bil_pkg::BIL_RST_CYC + 1);
  localparam logic [31:0] CMD =
    {bil_pkg::BIL_CMD_READ, bil_pkg::BIL_START_ADDR};

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ bil_pkg::BIL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  bil_pkg::bil_state_e state;
  bil_pkg::bil_state_e next_state;
  bil_pkg::bil_src_e   src;
  logic [TW-1:0]  tmr;
  logic [1:0]     bcnt;
  logic [31:0]    size;
  logic [33:0]    left;
  logic [31:0]    crc;
  logic [31:0]    field;
  logic [31:0]    ack_chan;
  logic [1:0]     mode_q;
  logic           tx_req;
  logic           rx_ack;
  logic           rx_req_q;
  logic [ADDR_W-1:0] wa;

  bil_sync3 #(.W(2)) u_mode (
    .clk_i (clock_i), .nrst_i(nrst_i), .d_i(boot_mode_i), .q_o(mode_q));

  // Byte sources
  logic       sp_vld;
  logic [7:0] sp_byte;
  logic       sv_vld;
  logic [7:0] sv_byte;
  logic       ot_vld;
  logic [7:0] ot_byte;
  logic [7:0] l_dat;
  logic       l_ctl;

  wire fetch = (state == bil_pkg::BIL_ST_SIZE) ||
               (state == bil_pkg::BIL_ST_PROG) ||
               (state == bil_pkg::BIL_ST_CRC);
  wire rd_st = fetch || (state == bil_pkg::BIL_ST_ACK) ||
               (state == bil_pkg::BIL_ST_END);
  wire lk_vld = rx_req_q ^ rx_ack;
  wire in_vld = (src == bil_pkg::BIL_SRC_LINK) ? lk_vld :
                (src == bil_pkg::BIL_SRC_SLV)  ? sv_vld :
                (src == bil_pkg::BIL_SRC_OTP)  ? ot_vld : sp_vld;
  wire [7:0] in_byte = (src == bil_pkg::BIL_SRC_LINK) ? l_dat :
                       (src == bil_pkg::BIL_SRC_SLV)  ? sv_byte :
                       (src == bil_pkg::BIL_SRC_OTP)  ? ot_byte : sp_byte;
  wire in_ctl = (src == bil_pkg::BIL_SRC_LINK) && l_ctl;
  wire take = in_vld && rd_st;
  wire [31:0] size_nx = {in_byte, size[31:8]};           // [RULE5]
  wire [31:0] crc_nx = crc_byte(crc, in_byte);           // [RULE8]
  wire crc_ok = (field == bil_pkg::BIL_CRC_SKIP) ||      // [RULE4]
                (~crc == field);                         // [RULE8]
  wire is_link = (src == bil_pkg::BIL_SRC_LINK);
  wire [bil_pkg::BIL_SEC_BIT:0] sec_lo = sec_word_i[bil_pkg::BIL_SEC_BIT:0];

  always_comb begin
    next_state = state;
    case (state)
      bil_pkg::BIL_ST_RST: if (tmr == TW'(bil_pkg::BIL_RST_CYC - 1))
        next_state = bil_pkg::BIL_ST_SEL;                // [RULE1]
      bil_pkg::BIL_ST_SEL: next_state = is_link ?
        bil_pkg::BIL_ST_LWAIT : bil_pkg::BIL_ST_SIZE;
      bil_pkg::BIL_ST_LWAIT: if (tmr == TW'(bil_pkg::BIL_LINK_CYC - 1))
        next_state = bil_pkg::BIL_ST_ACK;                // [RULE15]
      bil_pkg::BIL_ST_ACK: if (take && bcnt == 2'h3)
        next_state = bil_pkg::BIL_ST_SIZE;               // [RULE17]
      bil_pkg::BIL_ST_SIZE: if (take && bcnt == 2'h3)
        next_state = (size_nx == 32'h0) ?
          bil_pkg::BIL_ST_CRC : bil_pkg::BIL_ST_PROG;    // [RULE4]
      bil_pkg::BIL_ST_PROG: if (take && left == 34'h1)
        next_state = bil_pkg::BIL_ST_CRC;
      bil_pkg::BIL_ST_CRC: if (take && bcnt == 2'h3)
        next_state = is_link ? bil_pkg::BIL_ST_END : bil_pkg::BIL_ST_CHK;
      bil_pkg::BIL_ST_END:
        if (take && in_ctl && in_byte == bil_pkg::BIL_TOK_END)
          next_state = bil_pkg::BIL_ST_TXEND;            // [RULE17]
      bil_pkg::BIL_ST_TXEND: next_state = bil_pkg::BIL_ST_CHK;
      bil_pkg::BIL_ST_CHK: next_state = crc_ok ?
        bil_pkg::BIL_ST_JUMP : bil_pkg::BIL_ST_FAIL;     // [RULE20]
      default: next_state = state;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= bil_pkg::BIL_ST_RST;
      tmr   <= '0;
      bcnt  <= 2'h0;
    end else begin
      state <= next_state;
      tmr   <= (next_state != state) ? '0 : tmr + TW'(1);
      bcnt  <= (next_state != state) ? 2'h0 : bcnt + 2'(take);
    end
  end

  // Image parsing and load
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src   <= bil_pkg::BIL_SRC_QSPI;
      size  <= 32'h0;
      left  <= 34'h0;
      crc   <= bil_pkg::BIL_CRC_INIT;
      field <= 32'h0;
      ack_chan <= 32'h0;
      wa    <= '0;
      ram_we_o   <= 1'b0;
      ram_addr_o <= '0;
      ram_data_o <= 8'h00;
    end else begin
      ram_we_o <= 1'b0;
      if (state == bil_pkg::BIL_ST_SEL) begin
        crc <= bil_pkg::BIL_CRC_INIT;                    // [RULE8]
        wa  <= '0;                                       // [RULE6]
      end
      if (state == bil_pkg::BIL_ST_RST)
        src <= sec_lo[bil_pkg::BIL_SEC_BIT] ? bil_pkg::BIL_SRC_OTP :
               bil_pkg::bil_src_e'({1'b0, mode_q});      // [RULE3]
      if (take && state == bil_pkg::BIL_ST_ACK)
        ack_chan <= {in_byte, ack_chan[31:8]};
      if (take && state == bil_pkg::BIL_ST_SIZE) begin
        size <= size_nx;
        left <= {size_nx, 2'b00};
        crc  <= crc_nx;                                  // [RULE7]
      end
      if (take && state == bil_pkg::BIL_ST_PROG) begin
        crc  <= crc_nx;                                  // [RULE7]
        left <= left - 34'h1;
        ram_we_o   <= 1'b1;                              // [RULE6]
        ram_addr_o <= wa;
        ram_data_o <= in_byte;
        wa <= wa + ADDR_W'(1);
      end
      if (take && state == bil_pkg::BIL_ST_CRC)
        field <= {in_byte, field[31:8]};                 // [RULE5]
    end
  end

  // Pins, link enable and run status
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulldown_en_o <= 1'b1;                             // [RULE2]
      pin_en_o      <= 8'h00;
      link_en_o     <= 1'b0;
      chan_alloc_o  <= 1'b0;
      tx_req        <= 1'b0;
      run_o         <= 1'b0;
      run_addr_o    <= '0;
      fail_o        <= 1'b0;
    end else begin
      if (state == bil_pkg::BIL_ST_SEL)
        pin_en_o <= (src == bil_pkg::BIL_SRC_QSPI) ? bil_pkg::BIL_PINS_QSPI :
                    (src == bil_pkg::BIL_SRC_SPI)  ? bil_pkg::BIL_PINS_SPI :
                    (src == bil_pkg::BIL_SRC_SLV)  ? bil_pkg::BIL_PINS_SLV :
                    8'h00;                     // [RULE9] [RULE12] [RULE14]
      if (state == bil_pkg::BIL_ST_LWAIT && next_state != state) begin
        link_en_o    <= 1'b1;                            // [RULE15]
        chan_alloc_o <= 1'b1;                            // [RULE17]
      end
      if (state == bil_pkg::BIL_ST_TXEND) begin
        if (ack_chan != bil_pkg::BIL_NULL_CHAN)          // [RULE18]
          tx_req <= ~tx_req;                             // [RULE17]
        chan_alloc_o <= 1'b0;
      end
      if (state == bil_pkg::BIL_ST_JUMP) begin
        run_o         <= 1'b1;                           // [RULE6]
        pulldown_en_o <= 1'b0;
        pin_en_o      <= 8'h00;
      end
      fail_o <= fail_o || (state == bil_pkg::BIL_ST_FAIL); // [RULE20]
    end
  end

  // Flash master, mode 0, command then read
  wire       quad    = (src == bil_pkg::BIL_SRC_QSPI);
  wire       sp_go   = fetch && (quad || src == bil_pkg::BIL_SRC_SPI);
  wire [7:0] half    = quad ? bil_pkg::BIL_QSPI_HALF :
                              bil_pkg::BIL_SPI_HALF;     // [RULE9] [RULE12]
  logic [7:0]  hc;
  logic [5:0]  ccnt;
  logic [31:0] csr;
  logic [2:0]  rcnt;
  wire  [2:0]  step    = quad ? 3'h4 : 3'h1;
  wire         sp_last = quad ? rcnt[2] : (rcnt == 3'h7);
  wire  [7:0]  rsr_nx  = quad ? {dq_i, sp_byte[7:4]} :   // [RULE11]
                                {miso_i, sp_byte[7:1]};  // [RULE13]

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ss_n_o <= 1'b1;
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      hc <= 8'h00;
      ccnt <= 6'h00;
      csr <= 32'h0;
      rcnt <= 3'h0;
      sp_byte <= 8'h00;
      sp_vld <= 1'b0;
    end else begin
      sp_vld <= 1'b0;
      if (!sp_go) begin
        ss_n_o <= 1'b1;
        sclk_o <= 1'b0;
        mosi_oe_n_o <= 1'b1;
        ccnt <= 6'h00;
        rcnt <= 3'h0;
      end else if (ss_n_o) begin
        ss_n_o <= 1'b0;
        mosi_o <= CMD[31];                               // [RULE10]
        mosi_oe_n_o <= 1'b0;
        csr <= {CMD[30:0], 1'b0};
        hc <= half - 8'h01;
      end else if (hc != 8'h00) begin
        hc <= hc - 8'h01;
      end else begin
        hc <= half - 8'h01;
        sclk_o <= ~sclk_o;
        if (!sclk_o) begin
          if (ccnt != 6'h20) begin
            ccnt <= ccnt + 6'h01;
          end else begin
            sp_byte <= rsr_nx;
            rcnt <= rcnt + step;
            sp_vld <= sp_last;
          end
        end else if (ccnt != 6'h20) begin
          mosi_o <= csr[31];                             // [RULE10]
          csr <= {csr[30:0], 1'b0};
        end else if (quad) begin
          mosi_oe_n_o <= 1'b1;
        end
      end
    end
  end

  // External master: both modes sample on the rising edge
  logic [2:0] sv_q;
  logic       sck_d;
  logic [2:0] scnt;
  bil_sync3 #(.W(3)) u_slv (
    .clk_i (clock_i), .nrst_i(nrst_i),
    .d_i   ({slv_ss_n_i, slv_sclk_i, slv_mosi_i}), .q_o(sv_q));
  wire sv_rise = sv_q[1] && !sck_d;                      // [RULE14]

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_d <= 1'b0;
      scnt <= 3'h0;
      sv_byte <= 8'h00;
      sv_vld <= 1'b0;
    end else begin
      sck_d <= sv_q[1];
      sv_vld <= 1'b0;
      if (sv_q[2]) begin
        scnt <= 3'h0;
      end else if (sv_rise) begin
        sv_byte <= {sv_q[0], sv_byte[7:1]};              // [RULE13]
        scnt <= scnt + 3'h1;
        sv_vld <= (scnt == 3'h7);
      end
    end
  end

  // OTP: one word read, four bytes out low first
  logic [31:0] obuf;
  logic [2:0]  ocnt;
  logic        ot_busy;
  wire ot_go = fetch && (src == bil_pkg::BIL_SRC_OTP);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      otp_rd_o <= 1'b0;
      otp_addr_o <= '0;
      obuf <= 32'h0;
      ocnt <= 3'h0;
      ot_busy <= 1'b0;
      ot_vld <= 1'b0;
      ot_byte <= 8'h00;
    end else begin
      otp_rd_o <= 1'b0;
      ot_vld <= 1'b0;
      if (!ot_go) begin
        ot_busy <= 1'b0;
        ocnt <= 3'h0;
        if (!fetch)
          otp_addr_o <= '0;                              // [RULE19]
      end else if (ocnt != 3'h0) begin
        ot_vld <= 1'b1;
        ot_byte <= obuf[7:0];
        obuf <= obuf >> 8;
        ocnt <= ocnt - 3'h1;
      end else if (ot_busy) begin
        if (otp_vld_i) begin
          obuf <= otp_data_i;
          ocnt <= 3'h4;
          ot_busy <= 1'b0;
          otp_addr_o <= otp_addr_o + OTP_W'(1);
        end
      end else if (!ot_vld) begin
        otp_rd_o <= 1'b1;
        ot_busy <= 1'b1;
      end
    end
  end

  // Link side, on the link clock, toggle handshakes both ways
  logic [1:0]  lrs;
  logic [2:0]  lq;
  logic        rx_req_l;
  logic        tx_done_l;
  wire         lrst_n = lrs[1];
  wire         rx_acc = link_rx_valid_i && link_rx_ready_o;

  bil_sync3 #(.W(3)) u_l2c (
    .clk_i (link_clk_i), .nrst_i(lrst_n),
    .d_i   ({link_en_o, tx_req, rx_ack}), .q_o(lq));
  bil_sync3 #(.W(1)) u_c2l (
    .clk_i (clock_i), .nrst_i(nrst_i), .d_i(rx_req_l), .q_o(rx_req_q));

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      lrs <= 2'b00;
    else
      lrs <= {lrs[0], 1'b1};
  end

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      rx_req_l <= 1'b0;
      tx_done_l <= 1'b0;
      l_dat <= 8'h00;
      l_ctl <= 1'b0;
      link_rx_ready_o <= 1'b0;
      link_tx_valid_o <= 1'b0;
      link_tx_ctrl_o <= 1'b0;
      link_tx_data_o <= 8'h00;
      link_tx_chan_o <= 32'h0;
    end else begin
      link_tx_valid_o <= 1'b0;
      link_tx_ctrl_o <= 1'b0;
      link_tx_data_o <= 8'h00;                           // [RULE15]
      if (rx_acc) begin
        l_dat <= link_rx_data_i;
        l_ctl <= link_rx_ctrl_i;
        rx_req_l <= ~rx_req_l;
      end
      link_rx_ready_o <= lq[2] && !rx_acc && (lq[0] == rx_req_l);
      if (lq[1] != tx_done_l) begin
        tx_done_l <= ~tx_done_l;
        link_tx_valid_o <= 1'b1;
        link_tx_ctrl_o <= 1'b1;
        link_tx_data_o <= bil_pkg::BIL_TOK_END;          // [RULE17]
        link_tx_chan_o <= ack_chan;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i)
      rx_ack <= 1'b0;
    else if (take && is_link)
      rx_ack <= ~rx_ack;
  end
endmodule
`default_nettype wire

// ===== src/bil_pkg.sv
`default_nettype none
package bil_pkg;
  typedef enum logic [2:0] {
    BIL_SRC_QSPI = 3'h0,
    BIL_SRC_SPI  = 3'h1,
    BIL_SRC_SLV  = 3'h2,
    BIL_SRC_LINK = 3'h3,
    BIL_SRC_OTP  = 3'h4
  } bil_src_e;

  typedef enum logic [3:0] {
    BIL_ST_RST   = 4'h0,
    BIL_ST_SEL   = 4'h1,
    BIL_ST_LWAIT = 4'h2,
    BIL_ST_ACK   = 4'h3,
    BIL_ST_SIZE  = 4'h4,
    BIL_ST_PROG  = 4'h5,
    BIL_ST_CRC   = 4'h6,
    BIL_ST_END   = 4'h7,
    BIL_ST_TXEND = 4'h8,
    BIL_ST_CHK   = 4'h9,
    BIL_ST_JUMP  = 4'hA,
    BIL_ST_FAIL  = 4'hB
  } bil_state_e;

  localparam int BIL_CLK_KHZ  = 100000;
  localparam int BIL_RST_NS   = 15000;
  localparam int BIL_RST_CYC  =
    (BIL_RST_NS * BIL_CLK_KHZ + 999999) / 1000000;
  localparam int BIL_LINK_NS  = 2000;
  localparam int BIL_LINK_CYC = (BIL_LINK_NS * BIL_CLK_KHZ) / 1000000;
  // Serial clock ratios as for a 400 MHz core
  localparam int BIL_CORE_KHZ = 400000;
  localparam int BIL_QSPI_KHZ = 50000;
  localparam int BIL_SPI_KHZ  = 2500;
  localparam logic [7:0] BIL_QSPI_HALF =
    8'(BIL_CORE_KHZ / BIL_QSPI_KHZ / 2);
  localparam logic [7:0] BIL_SPI_HALF =
    8'(BIL_CORE_KHZ / BIL_SPI_KHZ / 2);

  localparam logic [7:0]  BIL_CMD_READ   = 8'h03;
  localparam logic [23:0] BIL_START_ADDR = 24'h000000;
  localparam logic [31:0] BIL_CRC_POLY   = 32'hEDB88320;
  localparam logic [31:0] BIL_CRC_INIT   = 32'hFFFFFFFF;
  localparam logic [31:0] BIL_CRC_SKIP   = 32'h0D15AB1E;
  localparam logic [31:0] BIL_NULL_CHAN  = 32'h0000FF02;
  localparam logic [7:0]  BIL_TOK_END    = 8'h01;
  localparam int          BIL_SEC_BIT    = 5;

  // Pin enable bits: ss, sclk, mosi, miso, dq0..dq3
  localparam logic [7:0] BIL_PINS_QSPI = 8'hF3;
  localparam logic [7:0] BIL_PINS_SPI  = 8'h0F;
  localparam logic [7:0] BIL_PINS_SLV  = 8'h07;
endpackage
`default_nettype wire
